// >>> hw/field_loss_impedance_detector.sv
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module field_loss_impedance_detector #(
  parameter int TICK_LEN = field_loss_pkg::TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic sample_valid_i,
  input wire logic signed [15:0] line_voltage_re_i,
  input wire logic signed [15:0] line_voltage_im_i,
  input wire logic signed [15:0] phase_current_first_re_i,
  input wire logic signed [15:0] phase_current_first_im_i,
  input wire logic signed [15:0] phase_current_second_re_i,
  input wire logic signed [15:0] phase_current_second_im_i,
  input wire logic interlock_input_one_i,
  input wire logic interlock_input_two_i,
  output logic trip_o,
  output logic irq_o
);
  import field_loss_pkg::*;

  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic rst_meta_ff;
  logic rst_sync_ff;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  wire rst_n = rst_sync_ff;

  // ------------------------------------------------------------
  // settings registers and apb slave
  // ------------------------------------------------------------
  logic field_loss_enable_setting_ff;
  logic [1:0] field_loss_lock_select_ff;
  logic [9:0] forward_reach_impedance_ff;
  logic [8:0] offset_reach_impedance_ff;
  logic [9:0] oper_delay_ff;
  logic [6:0] unlock_delay_ff;
  logic [NUM_EVENTS-1:0] irq_status_ff;
  logic [NUM_EVENTS-1:0] irq_enable_ff;
  logic [NUM_EVENTS-1:0] events;
  logic region_ff;
  logic stopper_ff;
  logic lock_ff;
  logic definitive_ff;

  // ------------------------------------------------------------
  // apb decode and read mux
  // ------------------------------------------------------------
  wire access = psel_i && penable_i && pready_o;
  wire wr = access && pwrite_i;
  logic known;
  logic [31:0] rdata;

  always_comb begin
    known = 1'b1;
    rdata = 32'h0;
    unique case (paddr_i)
      CTRL_OFF: rdata = {29'h0, field_loss_lock_select_ff, field_loss_enable_setting_ff};
      FWD_REACH_OFF: rdata = {22'h0, forward_reach_impedance_ff};
      OFS_REACH_OFF: rdata = {23'h0, offset_reach_impedance_ff};
      OPER_DELAY_OFF: rdata = {22'h0, oper_delay_ff};
      UNLOCK_DELAY_OFF: rdata = {25'h0, unlock_delay_ff};
      STATE_OFF: rdata = {27'h0, definitive_ff, lock_ff, stopper_ff, region_ff, trip_o};
      IRQ_STATUS_OFF: rdata = {29'h0, irq_status_ff};
      IRQ_ENABLE_OFF: rdata = {29'h0, irq_enable_ff};
      IRQ_CLEAR_OFF: rdata = 32'h0;
      default: known = 1'b0;
    endcase
  end

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0;
    end else begin
      pready_o <= psel_i && penable_i && !pready_o;
      pslverr_o <= psel_i && penable_i && !pready_o && !known;
      // read data launched together with pready
      if (psel_i && penable_i && !pready_o && !pwrite_i) begin
        prdata_o <= rdata;
      end
    end
  end

  // ------------------------------------------------------------
  // settings writes, clamped into their legal ranges
  // ------------------------------------------------------------
  function automatic logic [9:0] clamp10(input logic [31:0] v, input logic [9:0] lo,
                                         input logic [9:0] hi);
    if (v < {22'h0, lo}) begin
      return lo;
    end else if (v > {22'h0, hi}) begin
      return hi;
    end
    return v[9:0];
  endfunction

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      field_loss_enable_setting_ff <= 1'b0;
      field_loss_lock_select_ff <= LOCK_NONE;
      forward_reach_impedance_ff <= FWD_REACH_RST;
      offset_reach_impedance_ff <= OFS_REACH_RST;
      oper_delay_ff <= OPER_DELAY_RST;
      unlock_delay_ff <= UNLOCK_DELAY_RST;
      irq_enable_ff <= '0;
    end else if (wr) begin
      unique case (paddr_i)
        CTRL_OFF: begin
          field_loss_enable_setting_ff <= pwdata_i[CTRL_EN_BIT];
          field_loss_lock_select_ff <= pwdata_i[CTRL_LOCK_LSB +: 2];
        end
        FWD_REACH_OFF: forward_reach_impedance_ff <=
          clamp10(pwdata_i, FWD_REACH_MIN, FWD_REACH_MAX);
        OFS_REACH_OFF: offset_reach_impedance_ff <=
          9'(clamp10(pwdata_i, {1'b0, OFS_REACH_MIN}, {1'b0, OFS_REACH_MAX}));
        OPER_DELAY_OFF: oper_delay_ff <=
          clamp10(pwdata_i, OPER_DELAY_MIN, OPER_DELAY_MAX);
        UNLOCK_DELAY_OFF: unlock_delay_ff <=
          7'(clamp10(pwdata_i, 10'h0, {3'h0, UNLOCK_DELAY_MAX}));
        IRQ_ENABLE_OFF: irq_enable_ff <= pwdata_i[NUM_EVENTS-1:0];
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // phase comparator
  // ------------------------------------------------------------
  logic signed [31:0] cur_re;
  logic signed [31:0] cur_im;
  logic signed [31:0] volt_re;
  logic signed [31:0] volt_im;
  logic signed [31:0] zf;
  logic signed [31:0] zb;
  logic signed [31:0] v1_re;
  logic signed [31:0] v1_im;
  logic signed [31:0] v2_re;
  logic signed [31:0] v2_im;
  logic signed [63:0] dot;
  logic [63:0] cur_mag2;

  always_comb begin
    cur_re = 32'(phase_current_first_re_i) - 32'(phase_current_second_re_i);
    cur_im = 32'(phase_current_first_im_i) - 32'(phase_current_second_im_i);
    volt_re = 32'(line_voltage_re_i) * VOLT_SCALE;
    volt_im = 32'(line_voltage_im_i) * VOLT_SCALE;
    zf = $signed({22'h0, forward_reach_impedance_ff}) * FWD_TO_CENTI;
    zb = $signed({23'h0, offset_reach_impedance_ff});
    // v1 = v + j*zf*i, v2 = -(v + j*zb*i)
    v1_re = volt_re - zf * cur_im;
    v1_im = volt_im + zf * cur_re;
    v2_re = zb * cur_im - volt_re;
    v2_im = -(volt_im + zb * cur_re);
    // positive real part of v1*conj(v2): phase difference under 90 degrees
    dot = 64'(v1_re) * 64'(v2_re) + 64'(v1_im) * 64'(v2_im);
    // widen before squaring: a full-scale difference overflows 32 bits
    cur_mag2 = 64'(cur_re) * 64'(cur_re) + 64'(cur_im) * 64'(cur_im);
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      region_ff <= 1'b0;
      stopper_ff <= 1'b1;
    end else if (sample_valid_i) begin
      // the boundary itself counts as outside
      region_ff <= dot > 64'sh0;
      // equality still inhibits
      stopper_ff <= cur_mag2 <= STOPPER_MAG2;
    end
  end

  // ------------------------------------------------------------
  // 10 ms tick
  // ------------------------------------------------------------
  logic [31:0] presc_ff;
  logic tick_ff;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      presc_ff <= 32'h0;
      tick_ff <= 1'b0;
    end else begin
      // one-cycle pulse per 10 ms step
      tick_ff <= presc_ff == 32'(TICK_LEN - 1);
      presc_ff <= (presc_ff == 32'(TICK_LEN - 1)) ? 32'h0 : presc_ff + 32'h1;
    end
  end

  // ------------------------------------------------------------
  // operation interlock
  // ------------------------------------------------------------
  logic lock_in;
  logic [10:0] unlock_cnt_ff;
  logic [10:0] unlock_limit;
  // unlock delay in 0.1 s steps, counted in 10 ms ticks
  assign unlock_limit = 11'(unlock_delay_ff) * 11'(UNLOCK_STEP_TICKS);
  always_comb begin
    unique case (field_loss_lock_select_ff)
      LOCK_NONE: lock_in = 1'b0;
      LOCK_ONE: lock_in = interlock_input_one_i;
      LOCK_TWO: lock_in = interlock_input_two_i;
      LOCK_EITHER: lock_in = interlock_input_one_i || interlock_input_two_i;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      lock_ff <= 1'b0;
      unlock_cnt_ff <= 11'h0;
    end else if (lock_in) begin
      lock_ff <= 1'b1;
      unlock_cnt_ff <= 11'h0;
    end else if (lock_ff) begin
      if (unlock_cnt_ff >= unlock_limit) begin
        lock_ff <= 1'b0;
      end else if (tick_ff) begin
        unlock_cnt_ff <= unlock_cnt_ff + 11'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // operate delay and off-delay
  // ------------------------------------------------------------
  // enable, region, current and interlock must all allow
  wire operate = field_loss_enable_setting_ff && region_ff && !stopper_ff && !lock_ff;
  logic [9:0] oper_cnt_ff;
  logic [4:0] off_cnt_ff;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      oper_cnt_ff <= 10'h0;
      definitive_ff <= 1'b0;
    end else if (!operate) begin
      oper_cnt_ff <= 10'h0;
      definitive_ff <= 1'b0;
    end else if (oper_cnt_ff >= oper_delay_ff) begin
      definitive_ff <= 1'b1;
    end else if (tick_ff) begin
      oper_cnt_ff <= oper_cnt_ff + 10'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      off_cnt_ff <= 5'h0;
      trip_o <= 1'b0;
    end else if (!field_loss_enable_setting_ff) begin
      off_cnt_ff <= 5'h0;
      trip_o <= 1'b0;
    end else if (definitive_ff) begin
      off_cnt_ff <= OFF_DELAY_TICKS;
      trip_o <= 1'b1;
    end else if (off_cnt_ff != 5'h0) begin
      if (tick_ff) begin
        off_cnt_ff <= off_cnt_ff - 5'h1;
      end
      // drop together with the last step of the stretch
      trip_o <= !(tick_ff && off_cnt_ff == 5'h1);
    end else begin
      trip_o <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // interrupts
  // ------------------------------------------------------------
  logic trip_q_ff;
  logic lock_q_ff;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      trip_q_ff <= 1'b0;
      lock_q_ff <= 1'b0;
    end else begin
      trip_q_ff <= trip_o;
      lock_q_ff <= lock_ff;
    end
  end

  always_comb begin
    events = '0;
    events[EV_TRIP_SET] = trip_o && !trip_q_ff;
    events[EV_TRIP_CLR] = !trip_o && trip_q_ff;
    events[EV_LOCK_SET] = lock_ff && !lock_q_ff;
  end

  logic [NUM_EVENTS-1:0] clr_req;
  assign clr_req = (wr && paddr_i == IRQ_CLEAR_OFF) ? pwdata_i[NUM_EVENTS-1:0] : '0;

  // one sticky flop per event; set wins over a clear in the same cycle
  for (genvar b = 0; b < NUM_EVENTS; b++) begin : g_status
    always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
        irq_status_ff[b] <= 1'b0;
      end else if (events[b]) begin
        irq_status_ff[b] <= 1'b1;
      end else if (clr_req[b]) begin
        irq_status_ff[b] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status_ff & irq_enable_ff);
    end
  end
endmodule

// >>> hw/field_loss_pkg.sv
package field_loss_pkg;
  // ------------------------------------------------------------
  // register map (byte offsets)
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] FWD_REACH_OFF = 8'h04;
  localparam logic [7:0] OFS_REACH_OFF = 8'h08;
  localparam logic [7:0] OPER_DELAY_OFF = 8'h0c;
  localparam logic [7:0] UNLOCK_DELAY_OFF = 8'h10;
  localparam logic [7:0] STATE_OFF = 8'h14;
  localparam logic [7:0] IRQ_STATUS_OFF = 8'h18;
  localparam logic [7:0] IRQ_ENABLE_OFF = 8'h1c;
  localparam logic [7:0] IRQ_CLEAR_OFF = 8'h20;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_LOCK_LSB = 1;
  localparam int EV_TRIP_SET = 0;
  localparam int EV_TRIP_CLR = 1;
  localparam int EV_LOCK_SET = 2;
  localparam int NUM_EVENTS = 3;
  // ------------------------------------------------------------
  // setting ranges and reset values
  // ------------------------------------------------------------
  localparam logic [9:0] FWD_REACH_MIN = 10'h032;   // 5.0 ohm in 0.1 ohm
  localparam logic [9:0] FWD_REACH_MAX = 10'h1f4;   // 50.0 ohm
  localparam logic [9:0] FWD_REACH_RST = 10'h1f4;
  localparam logic [8:0] OFS_REACH_MIN = 9'h028;    // 0.40 ohm in 0.01 ohm
  localparam logic [8:0] OFS_REACH_MAX = 9'h190;    // 4.00 ohm
  localparam logic [8:0] OFS_REACH_RST = 9'h028;
  localparam logic [9:0] OPER_DELAY_MIN = 10'h014;  // 0.20 s in 0.01 s
  localparam logic [9:0] OPER_DELAY_MAX = 10'h3e8;  // 10.00 s
  localparam logic [9:0] OPER_DELAY_RST = 10'h064;
  localparam logic [6:0] UNLOCK_DELAY_MAX = 7'h64;  // 10.0 s in 0.1 s
  localparam logic [6:0] UNLOCK_DELAY_RST = 7'h00;
  // lock select codes
  localparam logic [1:0] LOCK_NONE = 2'h0;
  localparam logic [1:0] LOCK_ONE = 2'h1;
  localparam logic [1:0] LOCK_TWO = 2'h2;
  localparam logic [1:0] LOCK_EITHER = 2'h3;
  // ------------------------------------------------------------
  // scaling: voltage lsb 0.01 V, current lsb 0.01 A, reach 0.01 ohm
  // ------------------------------------------------------------
  localparam logic signed [31:0] VOLT_SCALE = 32'sh64;      // 100
  localparam logic signed [31:0] FWD_TO_CENTI = 32'sh0a;    // 0.1 -> 0.01 ohm
  localparam logic [63:0] STOPPER_MAG2 = 64'h6400;          // (2 x 0.8 A)^2 = 160^2
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int TICK_NS = 10_000_000;                      // 10 ms base tick
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int OFF_DELAY_MS = 200;
  localparam logic [4:0] OFF_DELAY_TICKS = 5'(OFF_DELAY_MS * 1_000_000 / TICK_NS);
  localparam logic [3:0] UNLOCK_STEP_TICKS = 4'ha;          // 0.1 s per step
endpackage

// >>> dv/field_loss_asserts.sv
`timescale 1ns/1ps
module field_loss_asserts #(
  parameter int TICK_LEN = 10
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic interlock_input_one_i,
  input wire logic interlock_input_two_i,
  input wire logic trip_o,
  input wire logic irq_o
);
  import field_loss_pkg::*;
  // ------------------------------------------------
  // shadow of settings written over apb
  // ------------------------------------------------
  logic wr_done;
  logic hit;
  logic en_ff;
  logic [1:0] sel_ff;
  logic [2:0] ien_ff;
  int unsigned on_cnt_ff;
  int unsigned hi_cnt_ff;
  assign wr_done = psel_i && penable_i && pready_o && pwrite_i;
  assign hit = (sel_ff[0] && interlock_input_one_i) || (sel_ff[1] && interlock_input_two_i);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      en_ff <= 1'b0;
      sel_ff <= 2'h0;
      ien_ff <= 3'h0;
    end else if (wr_done && paddr_i == CTRL_OFF) begin
      en_ff <= pwdata_i[CTRL_EN_BIT];
      sel_ff <= pwdata_i[2:1];
    end else if (wr_done && paddr_i == IRQ_ENABLE_OFF) begin
      ien_ff <= pwdata_i[2:0];
    end
  end
  // cycles enabled, cycles tripped
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      on_cnt_ff <= 0;
      hi_cnt_ff <= 0;
    end else begin
      on_cnt_ff <= en_ff ? on_cnt_ff + 1 : 0;
      hi_cnt_ff <= trip_o ? hi_cnt_ff + 1 : 0;
    end
  end
  // ------------------------------------------------
  // properties
  // ------------------------------------------------
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  ready_wait_a: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("access not ended after one wait state");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  err_map_a: assert property (pready_o && paddr_i[1:0] == 2'h0
    |-> pslverr_o == (paddr_i > IRQ_CLEAR_OFF)) else $error("error flag wrong for address");
  err_data_a: assert property (pslverr_o && !pwrite_i |-> prdata_o == 32'h0)
    else $error("refused read returned data");
  irq_mask_a: assert property ((ien_ff == 3'h0) [*2] |-> !irq_o)
    else $error("interrupt while all enables clear");
  en_off_a: assert property ((!en_ff) [*3] |-> !trip_o)
    else $error("trip while element disabled");
  lock_block_a: assert property (hit [*4] |-> !$rose(trip_o))
    else $error("trip rose while interlocked");
  delay_min_a: assert property ($rose(trip_o) |-> en_ff && on_cnt_ff >= 19 * TICK_LEN)
    else $error("trip before minimum operate delay");
  hold_min_a: assert property ($fell(trip_o) && en_ff && $past(en_ff)
    |-> $past(hi_cnt_ff) >= 18 * TICK_LEN) else $error("trip released before off delay");
endmodule

bind field_loss_impedance_detector field_loss_asserts #(.TICK_LEN(TICK_LEN)) u_chk (
  .clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
  .pready_o, .pslverr_o, .interlock_input_one_i, .interlock_input_two_i, .trip_o, .irq_o);

// >>> dv/vt_ct_model.sv
`timescale 1ns/1ps
module vt_ct_model (
  input wire logic clk_i,
  input wire logic signed [15:0] x_ohm_i,
  input wire logic signed [15:0] amp_i,
  output logic sample_valid_o = 1'b0,
  output logic signed [15:0] v_re_o = 16'sh0,
  output logic signed [15:0] v_im_o = 16'sh0,
  output logic signed [15:0] ia_re_o = 16'sh0,
  output logic signed [15:0] ia_im_o = 16'sh0,
  output logic signed [15:0] ib_re_o = 16'sh0,
  output logic signed [15:0] ib_im_o = 16'sh0
);
  // ------------------------------------------------
  // phasors every eighth cycle, inverted between
  // ------------------------------------------------
  logic [2:0] ph = 3'h0;
  logic signed [15:0] cm;
  logic signed [15:0] m;
  always @(posedge clk_i) begin
    cm = 16'($urandom_range(40, 0));
    m = {16{ph != 3'h0}};
    ph <= ph + 3'h1;
    sample_valid_o <= (ph == 3'h0);
    v_re_o <= m;
    v_im_o <= (x_ohm_i * amp_i * 16'sd2) ^ m;
    ia_re_o <= (amp_i + cm) ^ m;
    ia_im_o <= cm ^ m;
    ib_re_o <= (cm - amp_i) ^ m;
    ib_im_o <= cm ^ m;
  end
endmodule

// >>> dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import field_loss_pkg::*;
  localparam int TL = 10;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic interlock_input_one_i = 1'b0;
  logic interlock_input_two_i = 1'b0;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, trip_o, irq_o, sample_valid_i;
  logic signed [15:0] line_voltage_re_i, line_voltage_im_i;
  logic signed [15:0] phase_current_first_re_i, phase_current_first_im_i;
  logic signed [15:0] phase_current_second_re_i, phase_current_second_im_i;
  logic signed [15:0] x_ohm = 16'sh0;
  logic signed [15:0] amp = 16'sh0;
  logic [32:0] exp_q[$];
  int n_fail = 0;
  int comparisons = 0;
  int n;
  logic [7:0] ra[10] = '{CTRL_OFF, FWD_REACH_OFF, OFS_REACH_OFF, OPER_DELAY_OFF,
    UNLOCK_DELAY_OFF, IRQ_ENABLE_OFF, STATE_OFF, IRQ_STATUS_OFF, IRQ_CLEAR_OFF, 8'h24};
  logic [32:0] rv[10] = '{33'h0, 33'h1f4, 33'h28, 33'h64, 33'h0, 33'h0, 33'h4, 33'h0,
    33'h0, 33'h1_0000_0000};
  int xs[4] = '{-60, -45, -1, 10};
  logic [32:0] xv[4] = '{33'h0, 33'h2, 33'h2, 33'h0};

  initial forever #20 clk_i = ~clk_i;

  field_loss_impedance_detector #(.TICK_LEN(TL)) u_dut (
    .clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
    .pready_o, .pslverr_o, .sample_valid_i, .line_voltage_re_i, .line_voltage_im_i,
    .phase_current_first_re_i, .phase_current_first_im_i, .phase_current_second_re_i,
    .phase_current_second_im_i, .interlock_input_one_i, .interlock_input_two_i, .trip_o,
    .irq_o);
  vt_ct_model u_src (
    .clk_i, .x_ohm_i(x_ohm), .amp_i(amp), .sample_valid_o(sample_valid_i),
    .v_re_o(line_voltage_re_i), .v_im_o(line_voltage_im_i),
    .ia_re_o(phase_current_first_re_i), .ia_im_o(phase_current_first_im_i),
    .ib_re_o(phase_current_second_re_i), .ib_im_o(phase_current_second_im_i));

  // ------------------------------------------------
  // checking and closing
  // ------------------------------------------------
  task automatic chk(input logic [32:0] seen, input logic [32:0] want);
    comparisons++;
    if (seen !== want) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic wrap_up;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i) begin
      chk({pslverr_o, prdata_o}, exp_q.pop_front());
    end
  end

  // ------------------------------------------------
  // apb master and waits
  // ------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 50);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (k >= 50) begin
      n_fail++;
      wrap_up();
    end
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] want);
    exp_q.push_back(want);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic wait_trip(input logic lvl);
    n = 0;
    while (trip_o !== lvl && n < 1000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 1000) begin
      n_fail++;
      wrap_up();
    end
  endtask

  initial begin
    void'($urandom(98));
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    foreach (ra[i]) rd(ra[i], rv[i]);
    apb(1'b1, FWD_REACH_OFF, 32'h0);
    rd(FWD_REACH_OFF, 33'h32);
    apb(1'b1, OFS_REACH_OFF, 32'h3ff);
    rd(OFS_REACH_OFF, 33'h190);
    apb(1'b1, OPER_DELAY_OFF, 32'h5);
    rd(OPER_DELAY_OFF, 33'h14);
    apb(1'b1, FWD_REACH_OFF, 32'h1f4);
    apb(1'b1, OFS_REACH_OFF, 32'h28);
    apb(1'b1, 8'h24, 32'hffff_ffff);
    amp <= 16'sd100;
    foreach (xs[i]) begin
      x_ohm <= 16'(xs[i]);
      repeat (20) @(posedge clk_i);
      rd(STATE_OFF, xv[i]);
    end
    x_ohm <= -16'sd10;
    amp <= 16'sd80;
    repeat (20) @(posedge clk_i);
    rd(STATE_OFF, 33'h6);
    amp <= 16'sd81;
    repeat (250) @(posedge clk_i);
    rd(STATE_OFF, 33'h2);
    amp <= 16'sd100;
    apb(1'b1, IRQ_ENABLE_OFF, 32'h7);
    apb(1'b1, CTRL_OFF, 32'h1);
    wait_trip(1'b1);
    chk(33'(n >= 180 && n <= 230), 33'h1);
    repeat (3) @(posedge clk_i);
    chk({32'h0, irq_o}, 33'h1);
    apb(1'b1, IRQ_CLEAR_OFF, 32'h1);
    repeat (2) @(posedge clk_i);
    chk({32'h0, irq_o}, 33'h0);
    x_ohm <= 16'sd10;
    wait_trip(1'b0);
    chk(33'(n >= 185 && n <= 225), 33'h1);
    rd(IRQ_STATUS_OFF, 33'h2);
    apb(1'b1, IRQ_CLEAR_OFF, 32'h7);
    x_ohm <= -16'sd10;
    repeat (150) @(posedge clk_i);
    amp <= 16'sd80;
    repeat (20) @(posedge clk_i);
    amp <= 16'sd100;
    wait_trip(1'b1);
    chk(33'(n >= 180 && n <= 230), 33'h1);
    x_ohm <= 16'sd10;
    wait_trip(1'b0);
    apb(1'b1, CTRL_OFF, 32'h0);
    x_ohm <= -16'sd10;
    for (int s = 0; s < 4; s++) begin
      for (int p = 1; p < 3; p++) begin
        apb(1'b1, CTRL_OFF, 32'(s << 1));
        interlock_input_one_i <= p[0];
        interlock_input_two_i <= p[1];
        repeat (4) @(posedge clk_i);
        rd(STATE_OFF, 33'h2 | (33'((s[0] && p[0]) || (s[1] && p[1])) << 3));
        interlock_input_one_i <= 1'b0;
        interlock_input_two_i <= 1'b0;
      end
    end
    apb(1'b1, UNLOCK_DELAY_OFF, 32'h1);
    apb(1'b1, CTRL_OFF, 32'h2);
    interlock_input_one_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    interlock_input_one_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd(STATE_OFF, 33'ha);
    repeat (120) @(posedge clk_i);
    rd(STATE_OFF, 33'h2);
    apb(1'b1, CTRL_OFF, 32'h3);
    interlock_input_one_i <= 1'b1;
    repeat (300) @(posedge clk_i);
    chk({32'h0, trip_o}, 33'h0);
    rd(IRQ_STATUS_OFF, 33'h7);
    apb(1'b1, IRQ_ENABLE_OFF, 32'h0);
    repeat (2) @(posedge clk_i);
    chk({32'h0, irq_o}, 33'h0);
    wrap_up();
  end
endmodule
